// *** rtl/sr4_shift_register.sv ***
// 4-bit load/shift register with three-state bus outputs and serial output
// Summary of operation
// R1: Load select high: falling clock edge loads the four parallel inputs.
// R2: Load select low: falling edge shifts serial input into stage 0 upward.
// R3: Driver keeps select and data stable before the falling clock edge.
// R4: Clear low zeroes all stages at once, overriding clock and inputs.
// R5: Output enable controls all four bus outputs, never the register.
// R6: Enable low: bus outputs drive the stage values.
// R7: Enable high: bus outputs are released to high impedance.
// R8: Serial output always shows stage 3, never released.
// R9: Chained registers join serial output to next serial input.
// R10: Every falling edge outside clear performs either load or shift.
`timescale 1ns/1ps
module sr4_shift_register #(
  parameter int unsigned EDGE_DEPTH = sr4_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic shift_clock_n,
  input wire logic load_select,
  input wire logic serial_in,
  input wire logic [3:0] parallel_in,
  input wire logic clear_n,
  input wire logic output_enable_n,
  output logic [3:0] bus_out,
  output logic [3:0] bus_out_oe_n,
  output logic serial_out,
  output logic edge_ready_q
);
  // The clock pin is sampled on clk, so a falling pin edge is seen one
  // sample late and then queued; the queue is drained one entry per clk,
  // which keeps every register update two clk cycles behind its edge.
  localparam int unsigned OP_BITS = $bits(sr4_pkg::sr4_op_type);

  // Refuse settings that the queue and the stage logic cannot serve
  if (EDGE_DEPTH < 2 || (EDGE_DEPTH & (EDGE_DEPTH - 1)) != 0)
  begin : g_depth_check
    $error("sr4_shift_register: EDGE_DEPTH must be a power of two >= 2");
  end
  if (OP_BITS != sr4_pkg::OP_WIDTH)
  begin : g_op_check
    $error("sr4_shift_register: queue entry width must match the edge");
  end
  if (sr4_pkg::STAGES != 4)
  begin : g_stage_check
    $error("sr4_shift_register: the stage logic serves four stages");
  end
  // A tracker armed by reset would turn a low pin into a false edge
  if (sr4_pkg::CLOCK_PIN_RESET != 1'h0)
  begin : g_pin_check
    $error("sr4_shift_register: the pin tracker must reset disarmed");
  end
  // The bus drivers stay released while the block is in reset
  if (sr4_pkg::OE_N_RESET != 1'h1)
  begin : g_oe_check
    $error("sr4_shift_register: the bus must be released in reset");
  end

  // Level last seen on the clock pin; high arms the edge detector
  typedef enum logic {
    SR4_PIN_LOW = 1'h0,
    SR4_PIN_HIGH = 1'h1
  } sr4_pin_state_type;

  // Edge detector, queue, stages, driver enable and queue room
  sr4_pin_state_type pin_q, pin_d;
  logic fall;
  sr4_pkg::sr4_op_type edge_op, head_op;
  logic fifo_in_ready;
  logic head_valid;
  logic head_ready;
  logic [3:0] stage_q, stage_d;
  logic [3:0] oe_n_q, oe_n_d;
  logic ready_d;

  // Stage word after one captured edge: parallel load or shift toward stage 3
  function automatic logic [3:0] sr4_next_stages(
    input logic [3:0] cur,
    input sr4_pkg::sr4_op_type op
  );
    logic [3:0] nxt;
    nxt = cur;
    if (op.load)
      nxt = op.parallel; // see R1
    else
      nxt = {cur[2:0], op.serial}; // see R2 see R9
    return nxt;
  endfunction : sr4_next_stages

  // Packs the inputs as they stand at the sampled edge (see R3)
  function automatic sr4_pkg::sr4_op_type sr4_capture(
    input logic ld,
    input logic si,
    input logic [3:0] pd
  );
    sr4_pkg::sr4_op_type op;
    op.load = ld;
    op.serial = si;
    op.parallel = pd;
    return op;
  endfunction : sr4_capture

  // One enable level copied to all four bus drivers
  function automatic logic [3:0] sr4_oe_word(
    input logic oe_n
  );
    return {4{oe_n}};
  endfunction : sr4_oe_word

  // Falling edge of the clock pin; ignored while clear is held (see R4)
  always_comb
  begin
    pin_d = pin_q;
    fall = 1'h0;
    unique case (pin_q)
      SR4_PIN_LOW:
      begin
        if (shift_clock_n)
          pin_d = SR4_PIN_HIGH;
      end
      SR4_PIN_HIGH:
      begin
        if (!shift_clock_n)
        begin
          pin_d = SR4_PIN_LOW;
          fall = clear_n; // see R10
        end
      end
    endcase
  end

  // Tracker resets disarmed so a low pin after reset is not an edge
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pin_q <= sr4_pin_state_type'(sr4_pkg::CLOCK_PIN_RESET);
    else
      pin_q <= pin_d;
  end

  // Select and data as they stand when the pin is sampled
  always_comb
  begin
    edge_op = sr4_capture(load_select, serial_in, parallel_in);
  end

  // Edges wait here so that a register update never blocks the detector;
  // with one entry drained per clk the queue never fills in normal use.
  sr4_fifo #(
    .WIDTH(sr4_pkg::OP_WIDTH),
    .DEPTH(EDGE_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(fall),
    .in_ready(fifo_in_ready),
    .in_data(edge_op),
    .out_valid(head_valid),
    .out_ready(head_ready),
    .out_data(head_op)
  );

  // Pending edges are discarded while clear is held; applying them later
  // would bring back work that the clear cancelled.
  assign head_ready = 1'h1;

  // Clear wins, then one queued edge is applied per clk
  always_comb
  begin
    stage_d = stage_q;
    if (!clear_n)
      stage_d = sr4_pkg::STAGE_RESET; // see R4
    else if (head_valid)
      stage_d = sr4_next_stages(stage_q, head_op); // see R10
  end

  // Clear acts without the clock and wins over everything (see R4)
  always_ff @(posedge clk or negedge clear_n)
  begin
    if (!clear_n)
      stage_q <= sr4_pkg::STAGE_RESET;
    else if (sys_rst)
      stage_q <= sr4_pkg::STAGE_RESET;
    else
      stage_q <= stage_d;
  end

  // Enable only gates the drivers, never the stages (see R5)
  always_comb
  begin
    oe_n_d = sr4_oe_word(output_enable_n); // see R7
  end

  // Bus drivers follow the enable one clk later
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      oe_n_q <= sr4_oe_word(sr4_pkg::OE_N_RESET);
    else
      oe_n_q <= oe_n_d;
  end

  // Room in the queue for one more edge; low means a new edge is lost
  always_comb
  begin
    ready_d = fifo_in_ready;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      edge_ready_q <= 1'h0;
    else
      edge_ready_q <= ready_d;
  end

  // Outputs come straight from the registers above
  assign bus_out = stage_q; // see R6
  assign bus_out_oe_n = oe_n_q; // see R6 see R7
  assign serial_out = stage_q[3]; // see R8
endmodule : sr4_shift_register

// *** rtl/sr4_pkg.sv ***
// Constants and carrier types for the 4-bit three-state shift register
package sr4_pkg;
  localparam int unsigned STAGES = 4;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [3:0] STAGE_RESET = 4'h0;
  localparam logic OE_N_RESET = 1'h1;
  localparam logic CLOCK_PIN_RESET = 1'h0;
  localparam int unsigned OP_WIDTH = 6;

  // One captured clock-pin falling edge with its sampled inputs
  typedef struct packed {
    logic load;
    logic serial;
    logic [3:0] parallel;
  } sr4_op_type;
endpackage : sr4_pkg

// *** rtl/sr4_fifo.sv ***
// Parameterised FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sr4_fifo #(
  parameter int unsigned WIDTH = 6,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Refuse sizes that the pointer arithmetic cannot serve
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_depth_check
    $error("sr4_fifo: DEPTH must be a power of two of at least 2");
  end
  if (WIDTH < 1)
  begin : g_width_check
    $error("sr4_fifo: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic full_q, full_d, empty_q, empty_d;
  logic push, pop;

  always_comb
  begin
    push = in_valid && !full_q;
    pop = out_ready && !empty_q;
    wr_d = push ? wr_q + AW'(1) : wr_q;
    rd_d = pop ? rd_q + AW'(1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop)
      cnt_d = cnt_q + (AW+1)'(1);
    else if (pop && !push)
      cnt_d = cnt_q - (AW+1)'(1);
    full_d = (cnt_d == (AW+1)'(DEPTH));
    empty_d = (cnt_d == '0);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      full_q <= 1'h0;
      empty_q <= 1'h1;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      full_q <= full_d;
      empty_q <= empty_d;
    end
    if (push)
      mem_q[wr_q] <= in_data;
  end

  assign in_ready = !full_q;
  assign out_valid = !empty_q;
  assign out_data = mem_q[rd_q];
endmodule : sr4_fifo

// *** sim/sr4_props.sv ***
// Port properties of the shift register
`timescale 1ns/1ps
module sr4_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic shift_clock_n,
  input wire logic load_select,
  input wire logic serial_in,
  input wire logic [3:0] parallel_in,
  input wire logic clear_n,
  input wire logic output_enable_n,
  input wire logic [3:0] bus_out,
  input wire logic [3:0] bus_out_oe_n,
  input wire logic serial_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_clr; !clear_n |-> bus_out == 4'h0 && !serial_out; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_oe; !$past(sys_rst) |->
    bus_out_oe_n == {4{$past(output_enable_n)}}; endproperty
  a_oe: assert property (p_oe) else $error("enable");
  property p_ld; (clear_n && $fell(shift_clock_n) && load_select) ##1
    clear_n [*2] |-> bus_out == $past(parallel_in, 2); endproperty
  a_ld: assert property (p_ld) else $error("load");
  property p_sh; (clear_n && $fell(shift_clock_n) && !load_select) ##1
    clear_n [*2] |-> bus_out == {$past(bus_out[2:0]), $past(serial_in, 2)};
  endproperty
  a_sh: assert property (p_sh) else $error("shift");
  property p_so; serial_out == bus_out[3]; endproperty
  a_so: assert property (p_so) else $error("serial");
  property p_hold; (clear_n && !$fell(shift_clock_n)) ##1 clear_n [*2] |->
    $stable(bus_out); endproperty
  a_hold: assert property (p_hold) else $error("hold");
endmodule : sr4_props
bind sr4_shift_register sr4_props chk (.*);

// *** sim/sr4_bus_model.sv ***
// Shared three-state bus as other parties see it
`timescale 1ns/1ps
module sr4_bus_model (
  input wire logic clk,
  input wire logic [3:0] bus_out,
  input wire logic [3:0] bus_out_oe_n,
  output logic [3:0] bus_level
);
  // Released lines show the inverse so a stale value cannot pass
  assign bus_level = bus_out_oe_n[0] ? ~bus_out : bus_out;
endmodule : sr4_bus_model

// *** sim/sr4_shift_register_test.sv ***
// Corner and random tests of the shift register
`timescale 1ns/1ps
`define chk(n, e, a) begin total_checks++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module sr4_shift_register_test;
  logic clk = 0, sys_rst = 1, pin = 1, ld = 0, sin = 0, clr_n = 1, oe_n = 0;
  logic [3:0] par = 4'h0, q, oe, lvl, st = 4'h0;
  logic so, rdy;
  int fails = 0, total_checks = 0;
  always #2 clk = ~clk;
  sr4_shift_register dut (.clk(clk), .sys_rst(sys_rst), .shift_clock_n(pin),
    .load_select(ld), .serial_in(sin), .parallel_in(par), .clear_n(clr_n),
    .output_enable_n(oe_n), .bus_out(q), .bus_out_oe_n(oe), .serial_out(so),
    .edge_ready_q(rdy));
  sr4_bus_model bus (.clk(clk), .bus_out(q), .bus_out_oe_n(oe),
    .bus_level(lvl));
  function automatic logic [3:0] nxt(logic [3:0] s, logic l, logic i,
    logic [3:0] p);
    return l ? p : {s[2:0], i};
  endfunction : nxt
  task automatic op(logic l, logic i, logic [3:0] p, logic e);
    @(posedge clk) #1;
    {ld, sin, par, oe_n, pin} = {l, i, p, e, 1'b0};
    st = nxt(st, l, i, p);
    repeat (2) @(posedge clk);
    #1 pin = 1;
    @(posedge clk) #1;
    `chk("serial", st[3], so)
    `chk("enable", {4{e}}, oe)
    `chk("ready", 1'b1, rdy)
    if (!e) `chk("bus", st, lvl)
    else `chk("released", ~st, lvl)
  endtask : op
  task automatic clr();
    @(posedge clk) #1;
    {clr_n, pin} = 2'b00;
    #1 `chk("clear", 5'h00, {q, so})
    repeat (3) @(posedge clk);
    #1 {clr_n, pin} = 2'b11;
    st = sr4_pkg::STAGE_RESET;
  endtask : clr
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  initial
  begin
    void'($urandom(99));
    repeat (12) @(posedge clk);
    #1 sys_rst = 0;
    `chk("reset", 10'h03C, {q, oe, so, rdy})
    repeat (2) @(posedge clk);
    op(1, 0, 4'hF, 0);
    op(0, 0, 4'h0, 0);
    clr();
    op(1, 0, 4'hA, 1);
    op(0, 1, 4'h0, 0);
    op(0, so, 4'h0, 1);
    $display("corner tests done");
    repeat (200) op(1'($urandom), 1'($urandom), 4'($urandom), 1'($urandom));
    $display("random tests done");
    give_verdict();
  end
  initial
  begin
    #20000;
    fails++;
    give_verdict();
  end
endmodule : sr4_shift_register_test
